// ---- pkg/pem_pkg.sv ----
package pem_pkg;

	// System clock and the bench link clock, both in nanoseconds.
	localparam int CLK_NS      = 50;
	localparam int LINK_CLK_NS = 400;
	localparam int LINK_DIV    = LINK_CLK_NS / CLK_NS;

	// Longest times round down, least times round up, never below one cycle.
	function automatic int pem_max_cyc(input int ns);
		int c;
		c = ns / CLK_NS;
		return (c < 1) ? 1 : c;
	endfunction

	function automatic int pem_min_cyc(input int ns);
		int c;
		c = (ns + CLK_NS - 1) / CLK_NS;
		return (c < 1) ? 1 : c;
	endfunction

	// Reference clock periods of the two link modes, in nanoseconds.
	localparam real REDUCED_REFCLK_NS = 40.0;
	localparam real SERIAL_REFCLK_NS  = 8.0;

	// Link latency limits in nanoseconds and the cycle budgets they allow.
	localparam int RED_TXON_100_NS   = 235;
	localparam int RED_TXON_10_NS    = 1550;
	localparam int RED_TXOFF_100_NS  = 260;
	localparam int RED_TXOFF_10_NS   = 1250;
	localparam int RED_CRSON_100_NS  = 265;
	localparam int RED_CRSON_10_NS   = 1000;
	localparam int RED_CRSOFF_100_NS = 260;
	localparam int RED_CRSOFF_10_NS  = 570;
	localparam int RED_RXD_100_NS    = 160;
	localparam int RED_RXD_10_NS     = 1600;
	localparam int SER_TXOFF_100_NS  = 430;
	localparam int SER_TXOFF_10_NS   = 3800;
	localparam int SER_CRSON_100_NS  = 430;
	localparam int SER_CRSON_10_NS   = 680;
	localparam int SER_CRSOFF_100_NS = 420;
	localparam int SER_CRSOFF_10_NS  = 240;
	localparam int SER_DV_100_NS     = 470;
	localparam int SER_DV_10_NS      = 3840;
	// The tightest limit of all sets the fixed path latency of the device.
	localparam int TIGHTEST_CYC      = pem_max_cyc(RED_RXD_100_NS);

	// Reset and strap timing.
	localparam int RST_POR_MS        = 200;
	localparam int RST_POR_CYC       = RST_POR_MS * 1000000 / CLK_NS;
	localparam int RST_PULSE_NS      = 800;
	localparam int RST_PULSE_CYC     = pem_min_cyc(RST_PULSE_NS);
	localparam int STRAP_SETUP_NS    = 200;
	localparam int STRAP_SETUP_CYC   = pem_min_cyc(STRAP_SETUP_NS);
	localparam int STRAP_HOLD_NS     = 0;

	// Device register map, word indices on the device's own read port.
	localparam logic [4:0]  REG_ERR_TALLY   = 5'h1d;
	localparam logic [4:0]  REG_IRQ_SUMMARY = 5'h1e;
	localparam logic [4:0]  REG_PART_CODE   = 5'h1f;
	localparam logic [15:0] ERR_TALLY_RST   = 16'h0000;
	localparam logic [7:0]  IRQ_SUMMARY_RST = 8'h00;
	localparam int          IRQ_SUMMARY_LSB = 8;
	// Arbitrary neutral part code.
	localparam logic [15:0] PART_CODE_DEF   = 16'h5a3c;

	// Controller register map, byte addresses on the Wishbone bus.
	localparam logic [7:0] WB_CTRL    = 8'h00;
	localparam logic [7:0] WB_TXD     = 8'h04;
	localparam logic [7:0] WB_RDADDR  = 8'h08;
	localparam logic [7:0] WB_RDDATA  = 8'h0c;
	localparam logic [7:0] WB_LINK    = 8'h10;
	localparam logic [7:0] WB_IRQ_ST  = 8'h14;
	localparam logic [7:0] WB_IRQ_MSK = 8'h18;

	// Control field positions and reset values.
	localparam int         CTRL_REFDIR = 0;
	localparam int         CTRL_SERIAL = 1;
	localparam int         CTRL_RESET  = 2;
	localparam int         CTRL_TXEN   = 3;
	localparam logic [3:0] CTRL_RST    = 4'h0;

	// Interrupt status positions.
	localparam int IRQ_RD_DONE  = 0;
	localparam int IRQ_RST_DONE = 1;
	localparam int IRQ_CARRIER  = 2;
	localparam int IRQ_W        = 3;

	typedef enum logic [1:0] {HR_POR, HR_PULSE, HR_RUN} pem_rst_state_t;

endpackage

// ---- pkg/pem_if.sv ----
`timescale 1ns/1ps
interface pem_if;
	logic        phy_rst_n;
	logic        strap_refdir;
	logic        strap_serial;
	logic        refclk_dev_o;
	logic        refclk_dev_oe_n;
	logic        refclk_host_o;
	logic        refclk_host_oe_n;
	logic        refclk;
	logic        tx_en;
	logic [1:0]  txd;
	logic        crs_dv;
	logic        rx_valid;
	logic [1:0]  rxd;
	logic        rx_clk;
	logic        reg_req_tgl;
	logic [4:0]  reg_addr;
	logic        reg_ack_tgl;
	logic [15:0] reg_rdata;

	// Wire level of the shared reference clock; an undriven wire reads low.
	assign refclk = !refclk_dev_oe_n ? refclk_dev_o :
		(!refclk_host_oe_n ? refclk_host_o : 1'b0);

	modport dev (
		input  phy_rst_n, strap_refdir, strap_serial, refclk, tx_en, txd,
		input  reg_req_tgl, reg_addr,
		output refclk_dev_o, refclk_dev_oe_n, crs_dv, rx_valid, rxd, rx_clk,
		output reg_ack_tgl, reg_rdata
	);

	modport host (
		input  refclk, crs_dv, rx_valid, rxd, rx_clk, reg_ack_tgl, reg_rdata,
		output phy_rst_n, strap_refdir, strap_serial, refclk_host_o,
		output refclk_host_oe_n, tx_en, txd, reg_req_tgl, reg_addr
	);
endinterface

// ---- verilog/pem_phy_dev.sv ----
`timescale 1ns/1ps
// Operation
// RULE_01: Sixteen-bit error tally counts six event kinds.
// RULE_02: Port interrupt summary in upper byte, port 0.
// RULE_03: Summary bit follows port interrupt; low byte zero.
// RULE_04: Reduced mode: medium transmit starts promptly after enable.
// RULE_05: Reduced mode: medium transmit ends promptly after enable.
// RULE_06: Reduced mode: carrier-valid rises soon after signal.
// RULE_07: Reduced mode: carrier-valid falls soon after idle.
// RULE_08: Reduced mode: receive data soon after carrier-valid.
// RULE_09: Serial mode: medium transmit ends promptly.
// RULE_10: Serial mode: carrier sense rises promptly.
// RULE_11: Serial mode: carrier sense falls promptly.
// RULE_12: Serial mode: receive valid marked promptly.
// RULE_13: Reference clock direction follows strap select.
// RULE_14: Serial source-synchronous mode drives receive clock.
// RULE_15: Controller holds power-up reset long enough.
// RULE_16: Controller holds running reset pulse long enough.
// RULE_17: Straps sampled at reset release, setup ahead.
// RULE_18: Tally wraps and is not cleared by reads.
module pem_phy_dev #(
	parameter int          PORT_INDEX = 0,                      // Port number of this PHY port.
	parameter logic [15:0] PART_CODE  = pem_pkg::PART_CODE_DEF, // Arbitrary part code.
	parameter int          DIV        = pem_pkg::LINK_DIV       // Reference clock divider.
) (
	input  wire logic       clk_sys,       // System clock.
	input  wire logic       rst,           // Asynchronous reset, active high.
	input  wire logic       ce,            // Clock enable; low freezes all state.
	pem_if.dev              lnk,           // Link to the switch controller.
	input  wire logic       med_signal,    // Signal present on the medium.
	input  wire logic [1:0] med_rxd,       // Received dibit from the medium.
	input  wire logic [5:0] err_events,    // Error event pulses to tally.
	input  wire logic [7:0] port_irq,      // Interrupt level of each port.
	output logic            med_tx_active, // Transmitting on the medium.
	output logic [1:0]      med_txd,       // Dibit sent to the medium.
	output logic            strap_refdir_q, // Captured clock-direction strap.
	output logic            strap_serial_q  // Captured serial-mode strap.
);

	localparam int SW = 13;

	logic [SW-1:0] sync1_r;
	logic [SW-1:0] sync2_r;
	logic [SW-1:0] link_in;
	logic          rstn_s;
	logic          refdir_s;
	logic          serial_s;
	logic          refclk_s;
	logic          tx_en_s;
	logic [1:0]    txd_s;
	logic          req_s;
	logic [4:0]    addr_s;
	logic          rstn_d_r;
	logic          refclk_d_r;
	logic          req_d_r;
	logic [7:0]    div_cnt_r;
	logic          own_rise;
	logic          host_rise;
	logic          tx_rise;
	logic [15:0]   tally_r;

	// Adds up the events of one cycle so that coincident errors all count.
	function automatic logic [2:0] pem_ones(input logic [5:0] v);
		logic [2:0] n;
		n = 3'h0;
		for (int i = 0; i < 6; i++) begin
			n = n + {2'h0, v[i]};
		end
		return n;
	endfunction

	// Read multiplexer; unmapped indices read zero.
	function automatic logic [15:0] pem_read(input logic [4:0] a, input logic [15:0] t,
		input logic [7:0] irq);
		logic [15:0] d;
		d = 16'h0000;
		if (a == pem_pkg::REG_ERR_TALLY) begin
			d = t;
		end else if (a == pem_pkg::REG_IRQ_SUMMARY) begin
			d = {irq, 8'h00}; // RULE_03
		end else if (a == pem_pkg::REG_PART_CODE) begin
			d = PART_CODE;
		end
		return d;
	endfunction

	assign link_in = {lnk.phy_rst_n, lnk.strap_refdir, lnk.strap_serial, lnk.refclk,
		lnk.tx_en, lnk.txd, lnk.reg_req_tgl, lnk.reg_addr};

	// Every link pin comes from the controller's domain and passes two flops.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			sync1_r <= '0;
			sync2_r <= '0;
		end else if (ce) begin
			sync1_r <= link_in;
			sync2_r <= sync1_r;
		end
	end

	assign {rstn_s, refdir_s, serial_s, refclk_s, tx_en_s, txd_s, req_s, addr_s} = sync2_r;

	// Delayed copies for edge detection, taken from the second stage only.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			rstn_d_r   <= 1'b0;
			refclk_d_r <= 1'b0;
			req_d_r    <= 1'b0;
		end else if (ce) begin
			rstn_d_r   <= rstn_s;
			refclk_d_r <= refclk_s;
			req_d_r    <= req_s;
		end
	end

	// Straps are caught on the first cycle that sees the reset pin released.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			strap_refdir_q <= 1'b0;
			strap_serial_q <= 1'b0;
		end else if (ce && rstn_s && !rstn_d_r) begin
			strap_refdir_q <= refdir_s; // RULE_17
			strap_serial_q <= serial_s; // RULE_17
		end
	end

	// Own reference clock divider; it runs free, but the pin carries it only once the reset pin is released.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			div_cnt_r <= 8'h00;
		end else if (ce) begin
			div_cnt_r <= (div_cnt_r == 8'(DIV - 1)) ? 8'h00 : div_cnt_r + 8'h01;
		end
	end

	assign own_rise  = (div_cnt_r == 8'(DIV - 1));
	assign host_rise = refclk_s && !refclk_d_r;
	assign tx_rise   = strap_refdir_q ? host_rise : own_rise;

	// Clock pin is driven only when the strap says the device is the source.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			lnk.refclk_dev_o    <= 1'b0;
			lnk.refclk_dev_oe_n <= 1'b1;
		end else if (ce) begin
			lnk.refclk_dev_o    <= (div_cnt_r == 8'(DIV - 1)) || (div_cnt_r < 8'(DIV / 2 - 1));
			lnk.refclk_dev_oe_n <= !(rstn_s && !strap_refdir_q); // RULE_13
		end
	end

	// Source-synchronous receive clock mirrors the active reference clock.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			lnk.rx_clk <= 1'b0;
		end else if (ce) begin
			if (rstn_s && strap_serial_q) begin
				lnk.rx_clk <= strap_refdir_q ? refclk_s : lnk.refclk_dev_o; // RULE_14
			end else begin
				lnk.rx_clk <= 1'b0;
			end
		end
	end

	// Medium follows the synchronised enable directly, three cycles in all,
	// which sits inside the tightest latency; waiting for a slow link clock
	// edge here would break the 100 Mb/s limits.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			med_tx_active <= 1'b0;
		end else if (ce) begin
			med_tx_active <= rstn_s && tx_en_s; // RULE_04 RULE_05 RULE_09
		end
	end

	// Data dibits are taken at each reference clock rise while enabled.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			med_txd <= 2'h0;
		end else if (ce) begin
			if (!rstn_s || !tx_en_s) begin
				med_txd <= 2'h0;
			end else if (tx_rise) begin
				med_txd <= txd_s;
			end
		end
	end

	// Receive side answers the medium one cycle later in every mode.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			lnk.crs_dv   <= 1'b0;
			lnk.rx_valid <= 1'b0;
			lnk.rxd      <= 2'h0;
		end else if (ce) begin
			lnk.crs_dv   <= rstn_s && med_signal; // RULE_06 RULE_07 RULE_10 RULE_11
			lnk.rx_valid <= rstn_s && strap_serial_q && med_signal; // RULE_12
			lnk.rxd      <= (rstn_s && med_signal) ? med_rxd : 2'h0; // RULE_08
		end
	end

	// Error tally: cleared by the reset pin, wraps at the top, reads leave it.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			tally_r <= pem_pkg::ERR_TALLY_RST; // RULE_01
		end else if (ce) begin
			if (!rstn_s) begin
				tally_r <= pem_pkg::ERR_TALLY_RST;
			end else begin
				tally_r <= tally_r + {13'h0000, pem_ones(err_events)}; // RULE_01 RULE_18
			end
		end
	end

	// A read request is a toggle; the answer toggles back with data settled.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			lnk.reg_ack_tgl <= 1'b0;
			lnk.reg_rdata   <= 16'h0000;
		end else if (ce && (req_s != req_d_r)) begin
			lnk.reg_ack_tgl <= req_s;
			lnk.reg_rdata   <= pem_read(addr_s, tally_r,
				(PORT_INDEX == 0 && rstn_s) ? port_irq : pem_pkg::IRQ_SUMMARY_RST); // RULE_02
		end
	end

endmodule

// ---- verilog/pem_mac_host.sv ----
`timescale 1ns/1ps
module pem_mac_host #(
	parameter int POR_CYC = pem_pkg::RST_POR_CYC, // Power-up reset length in cycles.
	parameter int DIV     = pem_pkg::LINK_DIV     // Reference clock divider.
) (
	input  wire logic        clk_sys,  // System clock.
	input  wire logic        rst,      // Asynchronous reset, active high.
	input  wire logic        ce,       // Clock enable; low freezes all state.
	input  wire logic        wb_cyc_i, // Wishbone cycle.
	input  wire logic        wb_stb_i, // Wishbone strobe.
	input  wire logic        wb_we_i,  // Wishbone write enable.
	input  wire logic [7:0]  wb_adr_i, // Wishbone byte address.
	input  wire logic [3:0]  wb_sel_i, // Wishbone byte selects.
	input  wire logic [31:0] wb_dat_i, // Wishbone write data.
	output logic [31:0]      wb_dat_o, // Wishbone read data.
	output logic             wb_ack_o, // Wishbone acknowledge.
	output logic             irq,      // Level interrupt, active high.
	pem_if.host              lnk       // Link to the PHY.
);

	localparam int SW = 22;

	logic [SW-1:0]            sync1_r;
	logic [SW-1:0]            sync2_r;
	logic                     refclk_s;
	logic                     crs_s;
	logic                     rxv_s;
	logic [1:0]               rxd_s;
	logic                     ack_s;
	logic [15:0]              rdata_s;
	logic                     refclk_d_r;
	logic                     crs_d_r;
	logic [3:0]               ctrl_r;
	logic [1:0]               txd_r;
	logic [15:0]              rddata_r;
	logic                     busy_r;
	logic [pem_pkg::IRQ_W-1:0] irq_st_r;
	logic [pem_pkg::IRQ_W-1:0] irq_msk_r;
	logic [pem_pkg::IRQ_W-1:0] irq_set;
	pem_pkg::pem_rst_state_t  rst_st_r;
	logic [31:0]              rst_cnt_r;
	logic [31:0]              rst_len;
	logic [7:0]               div_cnt_r;
	logic                     wr;
	logic                     rd_go;
	logic                     rd_done;
	logic                     rst_done;

	assign wr = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0];
	assign rd_go   = wr && (wb_adr_i == pem_pkg::WB_RDADDR) && !busy_r;
	assign rd_done = busy_r && (ack_s == lnk.reg_req_tgl);
	assign rst_len = (rst_st_r == pem_pkg::HR_POR) ? 32'(POR_CYC) : 32'(pem_pkg::RST_PULSE_CYC);
	assign rst_done = (rst_st_r != pem_pkg::HR_RUN) && (rst_cnt_r >= rst_len - 32'h1);
	assign irq_set = {crs_s && !crs_d_r, rst_done, rd_done};

	// PHY outputs reach this end through two flops.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			sync1_r <= '0;
			sync2_r <= '0;
		end else if (ce) begin
			sync1_r <= {lnk.refclk, lnk.crs_dv, lnk.rx_valid, lnk.rxd, lnk.reg_ack_tgl,
				lnk.reg_rdata};
			sync2_r <= sync1_r;
		end
	end

	assign {refclk_s, crs_s, rxv_s, rxd_s, ack_s, rdata_s} = sync2_r;

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			refclk_d_r <= 1'b0;
			crs_d_r    <= 1'b0;
		end else if (ce) begin
			refclk_d_r <= refclk_s;
			crs_d_r    <= crs_s;
		end
	end

	// Reset sequencer: long power-up hold, then short pulses on request.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			rst_st_r  <= pem_pkg::HR_POR;
			rst_cnt_r <= 32'h0;
		end else if (ce) begin
			case (rst_st_r)
				pem_pkg::HR_POR, pem_pkg::HR_PULSE: begin
					if (rst_done) begin
						rst_st_r <= pem_pkg::HR_RUN; // RULE_15 RULE_16
					end else begin
						rst_cnt_r <= rst_cnt_r + 32'h1;
					end
				end
				default: begin
					rst_cnt_r <= 32'h0;
					if (wr && wb_adr_i == pem_pkg::WB_CTRL && wb_dat_i[pem_pkg::CTRL_RESET]) begin
						rst_st_r <= pem_pkg::HR_PULSE;
					end
				end
			endcase
		end
	end

	// Straps freeze a setup time before release; no hold is needed after it.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			lnk.phy_rst_n    <= 1'b0;
			lnk.strap_refdir <= 1'b0;
			lnk.strap_serial <= 1'b0;
		end else if (ce) begin
			lnk.phy_rst_n <= (rst_st_r == pem_pkg::HR_RUN) && !(wr &&
				wb_adr_i == pem_pkg::WB_CTRL && wb_dat_i[pem_pkg::CTRL_RESET]);
			// Straps wait until the device has let go of the clock pin.
			if (rst_st_r != pem_pkg::HR_RUN && rst_cnt_r >= 32'(pem_pkg::STRAP_SETUP_CYC) &&
				rst_cnt_r + 32'(pem_pkg::STRAP_SETUP_CYC) < rst_len) begin
				lnk.strap_refdir <= ctrl_r[pem_pkg::CTRL_REFDIR]; // RULE_17
				lnk.strap_serial <= ctrl_r[pem_pkg::CTRL_SERIAL];
			end
		end
	end

	// Own clock source, driven out only when the strap makes this end the source.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			div_cnt_r            <= 8'h00;
			lnk.refclk_host_o    <= 1'b0;
			lnk.refclk_host_oe_n <= 1'b1;
		end else if (ce) begin
			div_cnt_r            <= (div_cnt_r == 8'(DIV - 1)) ? 8'h00 : div_cnt_r + 8'h01;
			lnk.refclk_host_o    <= (div_cnt_r < 8'(DIV / 2));
			lnk.refclk_host_oe_n <= !lnk.strap_refdir; // RULE_13
		end
	end

	// Transmit lines change on a falling clock edge, far from the PHY's sampling rise.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			lnk.tx_en <= 1'b0;
			lnk.txd   <= 2'h0;
		end else if (ce && !refclk_s && refclk_d_r) begin
			lnk.tx_en <= ctrl_r[pem_pkg::CTRL_TXEN];
			lnk.txd   <= txd_r;
		end
	end

	// Register read toggle handshake toward the PHY.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			lnk.reg_req_tgl <= 1'b0;
			lnk.reg_addr    <= 5'h00;
			busy_r          <= 1'b0;
			rddata_r        <= 16'h0000;
		end else if (ce) begin
			if (rd_go) begin
				lnk.reg_addr    <= wb_dat_i[4:0];
				lnk.reg_req_tgl <= !lnk.reg_req_tgl;
				busy_r          <= 1'b1;
			end else if (rd_done) begin
				rddata_r <= rdata_s;
				busy_r   <= 1'b0;
			end
		end
	end

	// Control and mask registers; the reset bit is a pulse and does not store.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			ctrl_r    <= pem_pkg::CTRL_RST;
			txd_r     <= 2'h0;
			irq_msk_r <= '0;
		end else if (ce && wr) begin
			if (wb_adr_i == pem_pkg::WB_CTRL) begin
				ctrl_r <= wb_dat_i[3:0] & ~(4'h1 << pem_pkg::CTRL_RESET);
			end else if (wb_adr_i == pem_pkg::WB_TXD) begin
				txd_r <= wb_dat_i[1:0];
			end else if (wb_adr_i == pem_pkg::WB_IRQ_MSK) begin
				irq_msk_r <= wb_dat_i[pem_pkg::IRQ_W-1:0];
			end
		end
	end

	// Sticky status, write one to clear; a new event wins over the clear.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			irq_st_r <= '0;
			irq      <= 1'b0;
		end else if (ce) begin
			if (wr && wb_adr_i == pem_pkg::WB_IRQ_ST) begin
				irq_st_r <= (irq_st_r & ~wb_dat_i[pem_pkg::IRQ_W-1:0]) | irq_set;
			end else begin
				irq_st_r <= irq_st_r | irq_set;
			end
			irq <= |(irq_st_r & irq_msk_r);
		end
	end

	// Single-wait Wishbone slave; unmapped reads give zero.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0;
		end else if (ce) begin
			wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
			if (wb_adr_i == pem_pkg::WB_CTRL) begin
				wb_dat_o <= {28'h0, ctrl_r};
			end else if (wb_adr_i == pem_pkg::WB_TXD) begin
				wb_dat_o <= {30'h0, txd_r};
			end else if (wb_adr_i == pem_pkg::WB_RDADDR) begin
				wb_dat_o <= {27'h0, lnk.reg_addr};
			end else if (wb_adr_i == pem_pkg::WB_RDDATA) begin
				wb_dat_o <= {15'h0, busy_r, rddata_r};
			end else if (wb_adr_i == pem_pkg::WB_LINK) begin
				wb_dat_o <= {27'h0, !lnk.phy_rst_n, rxd_s, rxv_s, crs_s};
			end else if (wb_adr_i == pem_pkg::WB_IRQ_ST) begin
				wb_dat_o <= {29'h0, irq_st_r};
			end else if (wb_adr_i == pem_pkg::WB_IRQ_MSK) begin
				wb_dat_o <= {29'h0, irq_msk_r};
			end else begin
				wb_dat_o <= 32'h0;
			end
		end
	end

endmodule

// ---- tb/pem_link_asserts.sv ----
`timescale 1ns/1ps
// Watches the link between the two design ends and the device pins that the bench drives.
module pem_link_asserts #(
	parameter int POR_CYC = pem_pkg::RST_POR_CYC // Power-up hold in cycles.
) (
	input wire logic clk_sys,          // System clock.
	input wire logic rst,              // Asynchronous reset, active high.
	input wire logic phy_rst_n,        // Device reset pin.
	input wire logic strap_refdir,     // Clock-direction strap.
	input wire logic strap_serial,     // Serial-mode strap.
	input wire logic refclk_dev_oe_n,  // Device clock drive, low drives.
	input wire logic refclk_host_oe_n, // Host clock drive, low drives.
	input wire logic tx_en,            // Transmit enable.
	input wire logic crs_dv,           // Carrier.
	input wire logic rx_valid,         // Serial receive valid.
	input wire logic rx_clk,           // Serial receive clock.
	input wire logic med_signal,       // Medium signal present.
	input wire logic med_tx_active     // Medium transmit active.
);
	// Device output checks wait until its reset pin has been high for eight cycles,
	// since the device resynchronises that pin before it leaves its idle state.
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	// Cycles the reset pin has been low; only the first release owes the long hold.
	int unsigned low_cnt_r;
	logic        por_seen_r;
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			low_cnt_r  <= 32'h0;
			por_seen_r <= 1'b0;
		end else begin
			low_cnt_r  <= phy_rst_n ? 32'h0 : low_cnt_r + 32'h1;
			por_seen_r <= por_seen_r || phy_rst_n;
		end
	end

	rst_por_len_a: assert property ($rose(phy_rst_n) && !por_seen_r
		|-> low_cnt_r >= POR_CYC) else $error("power-up reset hold too short");
	rst_pulse_len_a: assert property ($fell(phy_rst_n) |-> (!phy_rst_n)[*8] ##1 (!phy_rst_n)[*8])
		else $error("reset pulse shorter than sixteen cycles");
	strap_setup_a: assert property ($rose(phy_rst_n) |-> strap_serial == $past(strap_serial, 4)
		&& strap_refdir == $past(strap_refdir, 4)) else $error("strap moved before reset release");
	refclk_host_a: assert property (strap_refdir && $past(strap_refdir) |-> !refclk_host_oe_n)
		else $error("host not driving reference clock");
	refclk_dev_a: assert property (phy_rst_n && $past(phy_rst_n, 8) && !strap_refdir
		|-> !refclk_dev_oe_n) else $error("device not driving reference clock");
	tx_start_a: assert property ($rose(tx_en) && $past(phy_rst_n, 8) |-> ##3 med_tx_active)
		else $error("medium transmit late");
	tx_finish_a: assert property ($fell(tx_en) && $past(phy_rst_n, 8) |-> ##3 !med_tx_active)
		else $error("medium transmit not finished");
	carrier_on_a: assert property ($rose(med_signal) && $past(phy_rst_n, 8) |=> crs_dv)
		else $error("carrier late");
	carrier_off_a: assert property ($fell(med_signal) && $past(phy_rst_n, 8) |=> !crs_dv)
		else $error("carrier not withdrawn");
	valid_on_a: assert property ($rose(med_signal) && $past(phy_rst_n, 8) && strap_serial
		|=> rx_valid) else $error("receive valid late");
	rxclk_idle_a: assert property (phy_rst_n && $past(phy_rst_n, 8) && !strap_serial
		|-> !rx_clk) else $error("receive clock outside serial mode");

	// Main scenarios reached.
	cover property ($fell(phy_rst_n));
	cover property ($rose(rx_valid));
	cover property ($fell(tx_en));
endmodule

// ---- tb/test_phy_error_irq_and_mii_latency.sv ----
`timescale 1ns/1ps
// Drives the controller over Wishbone and the device's outside pins.
module test_phy_error_irq_and_mii_latency;
	logic        clk_sys = 1'b0;
	logic        rst = 1'b1;
	logic        cyc = 1'b0;
	logic        stb = 1'b0;
	logic        we = 1'b0;
	logic [7:0]  adr = 8'h00;
	logic [31:0] dat = 32'h0;
	logic [31:0] q;
	logic [31:0] wb_dat_o;
	logic        wb_ack_o;
	logic        irq;
	logic        med_signal = 1'b0;
	logic [1:0]  med_rxd = 2'h0;
	logic [5:0]  err_events = 6'h00;
	logic [7:0]  port_irq = 8'ha5;
	logic        med_tx_active;
	logic        strap_refdir_q;
	logic        strap_serial_q;
	logic [1:0]  med_txd;
	logic [1:0]  m;
	int          error_cnt = 0;
	int          compares = 0;
	int          cyc_cnt = 0;

	pem_if lnk_if ();

	// Free-running system clock.
	initial begin
		forever #25 clk_sys = ~clk_sys;
	end

	pem_phy_dev pem_phy_dev_inst (.clk_sys(clk_sys), .rst(rst), .ce(1'b1), .lnk(lnk_if.dev),
		.med_signal(med_signal), .med_rxd(med_rxd), .err_events(err_events),
		.port_irq(port_irq), .med_tx_active(med_tx_active), .med_txd(med_txd),
		.strap_refdir_q(strap_refdir_q), .strap_serial_q(strap_serial_q));
	pem_mac_host #(.POR_CYC(40)) pem_mac_host_inst (.clk_sys(clk_sys), .rst(rst), .ce(1'b1),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
		.wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq(irq), .lnk(lnk_if.host));
	pem_link_asserts #(.POR_CYC(40)) pem_link_asserts_inst (.clk_sys(clk_sys), .rst(rst),
		.phy_rst_n(lnk_if.phy_rst_n), .strap_refdir(lnk_if.strap_refdir),
		.strap_serial(lnk_if.strap_serial), .refclk_dev_oe_n(lnk_if.refclk_dev_oe_n),
		.refclk_host_oe_n(lnk_if.refclk_host_oe_n), .tx_en(lnk_if.tx_en),
		.crs_dv(lnk_if.crs_dv), .rx_valid(lnk_if.rx_valid), .rx_clk(lnk_if.rx_clk),
		.med_signal(med_signal), .med_tx_active(med_tx_active));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// One classic cycle; the request stands until ack is sampled high.
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		do @(posedge clk_sys); while (wb_ack_o !== 1'b1);
		q = wb_dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask

	task automatic dev_rd(input logic [4:0] i, input logic [15:0] e);
		wb(1'b1, pem_pkg::WB_RDADDR, {27'h0, i});
		do wb(1'b0, pem_pkg::WB_RDDATA, 32'h0); while (q[16] !== 1'b0);
		chk({16'h0, q[15:0]}, {16'h0, e});
	endtask

	// Polls until the device reset has been released.
	task automatic wait_up;
		do wb(1'b0, pem_pkg::WB_IRQ_ST, 32'h0); while (q[1] !== 1'b1);
	endtask

	task automatic end_sim;
		$display("compares=%0d error_cnt=%0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// Hang guard; the wrap test alone takes about eleven thousand cycles.
	always @(posedge clk_sys) begin
		cyc_cnt++;
		if (cyc_cnt == 30000) begin
			error_cnt++;
			end_sim();
		end
	end

	initial begin
		repeat (6) @(posedge clk_sys);
		rst <= 1'b0;
		wb(1'b0, pem_pkg::WB_CTRL, 32'h0);
		chk(q, 32'h0);
		wb(1'b0, pem_pkg::WB_LINK, 32'h0);
		chk({31'h0, q[4]}, 32'h1);
		wb(1'b0, 8'h1c, 32'h0);
		chk(q, 32'h0);
		wait_up();
		chk({31'h0, irq}, 32'h0);
		wb(1'b1, pem_pkg::WB_IRQ_MSK, 32'h2);
		wb(1'b0, pem_pkg::WB_IRQ_MSK, 32'h0);
		chk({q[31:0]}, 32'h2);
		chk({31'h0, irq}, 32'h1);
		wb(1'b1, pem_pkg::WB_IRQ_ST, 32'h2);
		wb(1'b0, pem_pkg::WB_IRQ_ST, 32'h0);
		chk(q, 32'h0);
		chk({31'h0, irq}, 32'h0);
		dev_rd(5'h1d, 16'h0000);
		dev_rd(5'h1e, 16'ha500);
		port_irq <= 8'h5a;
		dev_rd(5'h1e, 16'h5a00);
		dev_rd(5'h1f, pem_pkg::PART_CODE_DEF);
		dev_rd(5'h1c, 16'h0000);
		err_events <= 6'h3f;
		@(posedge clk_sys);
		err_events <= 6'h01;
		@(posedge clk_sys);
		err_events <= 6'h00;
		dev_rd(5'h1d, 16'h0007);
		dev_rd(5'h1d, 16'h0007);
		err_events <= 6'h3f;
		repeat (10922) @(posedge clk_sys);
		err_events <= 6'h00;
		dev_rd(5'h1d, 16'h0003);
		wb(1'b0, pem_pkg::WB_IRQ_ST, 32'h0);
		chk({31'h0, q[0]}, 32'h1);
		// Every strap combination through a reset pulse, then receive and transmit.
		for (int i = 0; i < 4; i++) begin
			m = i[1:0];
			wb(1'b1, pem_pkg::WB_IRQ_ST, 32'h7);
			wb(1'b1, pem_pkg::WB_CTRL, {29'h0, 1'b1, m});
			wait_up();
			repeat (8) @(posedge clk_sys);
			chk({30'h0, strap_serial_q, strap_refdir_q}, {30'h0, m});
			dev_rd(5'h1d, 16'h0000);
			med_rxd <= 2'h2;
			med_signal <= 1'b1;
			repeat (3) @(posedge clk_sys);
			wb(1'b0, pem_pkg::WB_LINK, 32'h0);
			chk({28'h0, q[3:0]}, {28'h0, 2'h2, m[1], 1'b1});
			wb(1'b0, pem_pkg::WB_IRQ_ST, 32'h0);
			chk({31'h0, q[2]}, 32'h1);
			med_signal <= 1'b0;
			wb(1'b1, pem_pkg::WB_TXD, {30'h0, m ^ 2'h1});
			wb(1'b1, pem_pkg::WB_CTRL, {28'h0, 2'h2, m});
			repeat (24) @(posedge clk_sys);
			chk({29'h0, med_tx_active, med_txd}, {29'h0, 1'b1, m ^ 2'h1});
			wb(1'b1, pem_pkg::WB_CTRL, {30'h0, m});
			repeat (16) @(posedge clk_sys);
			chk({31'h0, med_tx_active}, 32'h0);
		end
		end_sim();
	end
endmodule
